// ### hw/ulms_defs.vh
// Constants shared by the serial-port status logic
`ifndef ULMS_DEFS_VH
`define ULMS_DEFS_VH
// ****************************************************************
// Register byte addresses
// ****************************************************************
`define ULMS_ADDR_U0_MODEM   32'hFFFF0718
`define ULMS_ADDR_U1_LINE    32'hFFFF0754
`define ULMS_ADDR_U1_MODEM   32'hFFFF0758
`define ULMS_ADDR_U1_CTRL    32'hFFFF075C
// ****************************************************************
// Reset values
// ****************************************************************
`define ULMS_RST_LINE        32'h000000E0
`define ULMS_RST_MODEM       32'h00000000
`define ULMS_RST_CTRL        8'h00
// ****************************************************************
// Line status field positions
// ****************************************************************
`define ULMS_LS_RXERR        11
`define ULMS_LS_TIMEOUT      10
`define ULMS_LS_TRIG         9
`define ULMS_LS_TXFULL       8
`define ULMS_LS_TXHALF       7
`define ULMS_LS_TRANSMITTER_IDLE         6
`define ULMS_LS_HOLDING_STAGE_EMPTY         5
`define ULMS_LS_BREAK        4
`define ULMS_LS_FRAME        3
`define ULMS_LS_PARITY       2
`define ULMS_LS_OVERRUN      1
`define ULMS_LS_READY        0
// ****************************************************************
// Modem status field positions
// ****************************************************************
`define ULMS_MS_DCD          7
`define ULMS_MS_RI           6
`define ULMS_MS_DSR          5
`define ULMS_MS_CTS          4
`define ULMS_MS_CARRIER_CHANGED         3
`define ULMS_MS_RING_TRAILING_EDGE         2
`define ULMS_MS_SET_READY_CHANGED         1
`define ULMS_MS_CLEAR_TO_SEND_CHANGED         0
// ****************************************************************
// Control register fields and timing counts (bit ticks)
// ****************************************************************
`define ULMS_CTRL_FIFO       0
`define ULMS_CTRL_TRIG_LO    5
`define ULMS_CTRL_TRIG_HI    7
`define ULMS_CHAR_BITS       10
`define ULMS_TIMEOUT_CHARS   4
`define ULMS_MAX_WORD_BITS   12
`endif

// ### hw/ulms_modem_delta.v
// Modem handshake status with change detection cleared on read
`timescale 1ns/1ps
`include "ulms_defs.vh"
module ulms_modem_delta
(
  input  wire       pclk,
  input  wire       presetn,
  input  wire       dcd,
  input  wire       ri,
  input  wire       dsr,
  input  wire       cts,
  input  wire       rd_clr,
  input  wire [3:0] clr_mask,
  output wire [7:0] status
);
  reg  [3:0] prev_ff;
  reg  [3:0] delta_ff;
  wire [3:0] cur;
  wire [3:0] chg;
  wire [3:0] nxt_delta;

  assign cur = {dcd, ri, dsr, cts};
  // Ring flags only the rising edge; the others any change
  assign chg = {prev_ff[3] ^ dcd,                      // RULE_15
                ~prev_ff[2] & ri,                      // RULE_16
                prev_ff[1] ^ dsr,                      // RULE_17
                prev_ff[0] ^ cts};                     // RULE_18
  // Only bits software actually saw are cleared; a new change wins
  assign nxt_delta = (delta_ff & ~({4{rd_clr}} & clr_mask)) | chg;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_ff  <= 4'h0;
      delta_ff <= 4'h0;
    end
    else
    begin
      prev_ff  <= cur;
      delta_ff <= nxt_delta;
    end
  end

  assign status = {cur, delta_ff};                     // RULE_19
endmodule // ulms_modem_delta

// ### hw/ulms_rx_timeout.v
// Receive FIFO timeout: four character times without FIFO access
`timescale 1ns/1ps
`include "ulms_defs.vh"
module ulms_rx_timeout
#(
  parameter TICKS = `ULMS_TIMEOUT_CHARS * `ULMS_CHAR_BITS
)
(
  input  wire pclk,
  input  wire presetn,
  input  wire fifo_mode,
  input  wire bit_tick,
  input  wire rx_nonempty,
  input  wire rx_access,
  output wire timeout
);
  reg  [7:0] cnt_ff;
  reg        flag_ff;
  reg  [7:0] nxt_cnt;
  reg        nxt_flag;

  always @*
  begin
    nxt_cnt  = cnt_ff;
    nxt_flag = flag_ff;
    if (!fifo_mode || !rx_nonempty || rx_access)
    begin
      nxt_cnt  = 8'h00;
      nxt_flag = 1'b0;
    end
    else if (bit_tick && !flag_ff)
    begin
      nxt_cnt = cnt_ff + 8'h01;
      if (nxt_cnt == TICKS[7:0])
        nxt_flag = 1'b1;                               // RULE_02
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff  <= 8'h00;
      flag_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      flag_ff <= nxt_flag;
    end
  end

  assign timeout = flag_ff;
endmodule // ulms_rx_timeout

// ### hw/ulms_status.v
// Serial-port line and modem status registers behind an APB slave
// Operation
// RULE_01: Error summary bit 11 is parity or framing or break flag.
// RULE_02: FIFO mode: bit 10 sets after four idle character times with data queued.
// RULE_03: FIFO mode: bit 9 high while receive count exceeds trigger level.
// RULE_04: FIFO mode: bit 8 high while transmit FIFO is full.
// RULE_05: FIFO mode: bit 7 high while transmit FIFO holds eight or fewer.
// RULE_06: Bit 6 high only when holding stage or FIFO and shifter are empty.
// RULE_07: Bit 5 high when holding stage or FIFO is empty.
// RULE_08: Bit 4 sets when receive line stays low beyond longest character.
// RULE_09: Bit 3 sets on a bad stop bit, clears itself.
// RULE_10: Bit 2 sets on a parity failure, clears itself.
// RULE_11: Non-FIFO: bit 1 sets when unread data is overwritten.
// RULE_12: FIFO: overrun only when full and another character completes; it is not stored.
// RULE_13: Non-FIFO: bit 0 sets on received byte, clears on buffer read.
// RULE_14: FIFO: bit 0 high while any unread byte remains.
// RULE_15: Modem bit 3 flags a carrier-detect change since last read.
// RULE_16: Modem bit 2 flags ring rising edge since last read.
// RULE_17: Modem bit 1 flags a set-ready change since last read.
// RULE_18: Modem bit 0 flags a clear-to-send change since last read.
// RULE_19: Modem bits 7..4 show carrier, ring, set-ready, clear-to-send levels.
// RULE_20: FIFO-only flags read zero in non-FIFO mode; bit 7 is not gated and reads one there while eight or fewer are queued.
`timescale 1ns/1ps
`include "ulms_defs.vh"
module ulms_status
#(
  parameter RX_DEPTH = 16,
  parameter TX_DEPTH = 16,
  parameter TX_HALF  = 8,
  parameter CNT_W    = 5
)
(
  input  wire             pclk,
  input  wire             presetn,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [31:0]      paddr,
  input  wire [31:0]      pwdata,
  output wire [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  input  wire             serial_receive_input,
  input  wire             bit_tick,
  input  wire             rx_char_done,
  input  wire             rx_parity_bad,
  input  wire             rx_stop_bad,
  input  wire             receive_buffer_read,
  input  wire [CNT_W-1:0] rx_fifo_count,
  input  wire             rx_fifo_access,
  input  wire [CNT_W-1:0] tx_fifo_count,
  input  wire             tx_holding_full,
  input  wire             tx_shift_busy,
  input  wire             u0_dcd,
  input  wire             u0_ri,
  input  wire             u0_dsr,
  input  wire             u0_cts,
  input  wire             u1_dcd,
  input  wire             u1_ri,
  input  wire             u1_dsr,
  input  wire             u1_cts,
  output wire             fifo_mode,
  output wire [2:0]       rx_trigger_code,
  output wire             rx_store_block
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function hit;
    input [31:0] a;
    input [31:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // Trigger level is two bytes per code step
  function [CNT_W-1:0] trig_thresh;
    input [2:0] code;
    begin
      trig_thresh = {{(CNT_W-4){1'b0}}, code, 1'b0};
    end
  endfunction

  localparam [CNT_W-1:0] RX_FULL_CNT = RX_DEPTH[CNT_W-1:0];
  localparam [CNT_W-1:0] TX_FULL_CNT = TX_DEPTH[CNT_W-1:0];
  localparam [CNT_W-1:0] TX_HALF_CNT = TX_HALF[CNT_W-1:0];
  localparam [CNT_W-1:0] CNT_ZERO    = {CNT_W{1'b0}};
  // One tick past the longest word, so a full-length character never trips it
  localparam integer     BREAK_TICKS_I = `ULMS_MAX_WORD_BITS + 1;
  localparam [4:0]       BREAK_TICKS = BREAK_TICKS_I[4:0];
  localparam [1:0]       SEL_NONE    = 2'h0;
  localparam [1:0]       SEL_LINE    = 2'h1;
  localparam [1:0]       SEL_M0      = 2'h2;
  localparam [1:0]       SEL_M1      = 2'h3;

  // ****************************************************************
  // State
  // ****************************************************************
  reg  [31:0] prdata_ff;
  reg         pready_ff;
  reg         pslverr_ff;
  reg  [1:0]  sel_ff;
  reg  [7:0]  ctrl_ff;
  reg         parity_ff;
  reg         frame_ff;
  reg         break_ff;
  reg         overrun_ff;
  reg         ready_ff;
  reg  [4:0]  low_cnt_ff;
  reg         low_seen_ff;
  reg         store_block_ff;
  reg  [31:0] nxt_prdata;
  reg  [1:0]  nxt_sel;
  reg         nxt_err;
  reg  [4:0]  nxt_low_cnt;
  reg         nxt_low_seen;
  reg         brk_set;

  wire        setup;
  wire        done;
  wire        rd_done;
  wire        line_clr;
  wire        fifo_on;
  wire        rx_full;
  wire        ovr_set;
  wire        timeout;
  wire        tx_empty;
  wire [11:0] line_now;
  wire [7:0]  m0_status;
  wire [7:0]  m1_status;

  assign setup   = psel & ~penable;
  assign done    = psel & penable & pready_ff;
  // A refused access clears no flag
  assign rd_done = done & ~pwrite & ~pslverr_ff;
  assign fifo_on = ctrl_ff[`ULMS_CTRL_FIFO];
  assign rx_full = (rx_fifo_count == RX_FULL_CNT);

  // ****************************************************************
  // Modem status, two ports
  // ****************************************************************
  ulms_modem_delta u_m0
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .dcd      (u0_dcd),
    .ri       (u0_ri),
    .dsr      (u0_dsr),
    .cts      (u0_cts),
    .rd_clr   (rd_done & (sel_ff == SEL_M0)),
    .clr_mask (prdata_ff[3:0]),
    .status   (m0_status)
  );

  ulms_modem_delta u_m1
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .dcd      (u1_dcd),
    .ri       (u1_ri),
    .dsr      (u1_dsr),
    .cts      (u1_cts),
    .rd_clr   (rd_done & (sel_ff == SEL_M1)),
    .clr_mask (prdata_ff[3:0]),
    .status   (m1_status)
  );

  ulms_rx_timeout u_tmo
  (
    .pclk        (pclk),
    .presetn     (presetn),
    .fifo_mode   (fifo_on),
    .bit_tick    (bit_tick),
    .rx_nonempty (rx_fifo_count != CNT_ZERO),
    .rx_access   (rx_fifo_access),
    .timeout     (timeout)
  );

  // ****************************************************************
  // Receive error flags
  // ****************************************************************
  // A read clears only the flags it returned, so nothing raised
  // between the data capture and the completion is lost
  assign line_clr = rd_done & (sel_ff == SEL_LINE);
  // Non-FIFO overrun needs unread data; FIFO overrun needs a full queue
  assign ovr_set  = rx_char_done & (fifo_on ? rx_full : ready_ff); // RULE_11 RULE_12

  always @*
  begin
    nxt_low_cnt  = low_cnt_ff;
    nxt_low_seen = low_seen_ff;
    brk_set      = 1'b0;
    if (serial_receive_input)
    begin
      nxt_low_cnt  = 5'h00;
      nxt_low_seen = 1'b0;
    end
    // One flag per low stretch; the count rests until the line goes high
    else if (bit_tick && !low_seen_ff)
    begin
      nxt_low_cnt = low_cnt_ff + 5'h01;
      if (nxt_low_cnt == BREAK_TICKS)
      begin
        brk_set      = 1'b1;                           // RULE_08
        nxt_low_seen = 1'b1;
      end
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      parity_ff      <= 1'b0;
      frame_ff       <= 1'b0;
      break_ff       <= 1'b0;
      overrun_ff     <= 1'b0;
      ready_ff       <= 1'b0;
      low_cnt_ff     <= 5'h00;
      low_seen_ff    <= 1'b0;
      store_block_ff <= 1'b0;
    end
    else
    begin
      low_cnt_ff  <= nxt_low_cnt;
      low_seen_ff <= nxt_low_seen;
      parity_ff   <= (parity_ff & ~(line_clr & prdata_ff[`ULMS_LS_PARITY]))
                     | (rx_char_done & rx_parity_bad);            // RULE_10
      frame_ff    <= (frame_ff & ~(line_clr & prdata_ff[`ULMS_LS_FRAME]))
                     | (rx_char_done & rx_stop_bad);              // RULE_09
      break_ff    <= (break_ff & ~(line_clr & prdata_ff[`ULMS_LS_BREAK]))
                     | brk_set;                                   // RULE_08
      overrun_ff  <= (overrun_ff & ~(line_clr & prdata_ff[`ULMS_LS_OVERRUN]))
                     | ovr_set;                                   // RULE_11
      // Non-FIFO data ready: new byte wins over a same-cycle buffer read
      ready_ff    <= (ready_ff & ~receive_buffer_read)
                     | (rx_char_done & ~fifo_on);                 // RULE_13
      // Tells the datapath not to push into a full FIFO
      store_block_ff <= fifo_on & rx_full;                        // RULE_12
    end
  end

  // ****************************************************************
  // Transmit side
  // ****************************************************************
  // Holding stage or queue, whichever the mode uses, has nothing left
  assign tx_empty = fifo_on ? (tx_fifo_count == CNT_ZERO) : ~tx_holding_full;

  // ****************************************************************
  // Live line status
  // ****************************************************************
  assign line_now[`ULMS_LS_RXERR]   = parity_ff | frame_ff | break_ff;  // RULE_01
  assign line_now[`ULMS_LS_TIMEOUT] = fifo_on & timeout;                // RULE_02 RULE_20
  assign line_now[`ULMS_LS_TRIG]    = fifo_on &
    (rx_fifo_count > trig_thresh(ctrl_ff[`ULMS_CTRL_TRIG_HI:`ULMS_CTRL_TRIG_LO])); // RULE_03
  assign line_now[`ULMS_LS_TXFULL]  = fifo_on & (tx_fifo_count == TX_FULL_CNT);  // RULE_04
  // Half-empty stays ungated: the queue count is zero outside FIFO mode,
  // which keeps the reset image of the line register at 0xE0
  assign line_now[`ULMS_LS_TXHALF]  = (tx_fifo_count <= TX_HALF_CNT);            // RULE_05
  assign line_now[`ULMS_LS_TRANSMITTER_IDLE]    = ~tx_shift_busy & tx_empty;                 // RULE_06
  assign line_now[`ULMS_LS_HOLDING_STAGE_EMPTY]    = tx_empty;                                  // RULE_07
  assign line_now[`ULMS_LS_BREAK]   = break_ff;
  assign line_now[`ULMS_LS_FRAME]   = frame_ff;
  assign line_now[`ULMS_LS_PARITY]  = parity_ff;
  assign line_now[`ULMS_LS_OVERRUN] = overrun_ff;
  assign line_now[`ULMS_LS_READY]   =
    fifo_on ? (rx_fifo_count != CNT_ZERO) : ready_ff;                            // RULE_13 RULE_14

  // ****************************************************************
  // APB slave: one wait-free access phase, data captured at setup
  // ****************************************************************
  always @*
  begin
    nxt_prdata = 32'h00000000;
    nxt_sel    = SEL_NONE;
    nxt_err    = 1'b0;
    if (hit(paddr, `ULMS_ADDR_U1_LINE))
    begin
      nxt_sel    = SEL_LINE;
      nxt_prdata = {20'h00000, line_now};
      nxt_err    = pwrite;
    end
    else if (hit(paddr, `ULMS_ADDR_U0_MODEM))
    begin
      nxt_sel    = SEL_M0;
      nxt_prdata = {24'h000000, m0_status};
      nxt_err    = pwrite;
    end
    else if (hit(paddr, `ULMS_ADDR_U1_MODEM))
    begin
      nxt_sel    = SEL_M1;
      nxt_prdata = {24'h000000, m1_status};
      nxt_err    = pwrite;
    end
    else if (hit(paddr, `ULMS_ADDR_U1_CTRL))
      nxt_prdata = {24'h000000, ctrl_ff};
    else
      nxt_err = 1'b1;
    // Writes return no data, so nothing stale is left on the read bus
    if (pwrite)
      nxt_prdata = 32'h00000000;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff  <= 32'h00000000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      sel_ff     <= SEL_NONE;
      ctrl_ff    <= `ULMS_RST_CTRL;
    end
    else
    begin
      // Zero wait states: the answer always follows the setup cycle
      pready_ff <= setup;
      if (setup)
      begin
        prdata_ff  <= nxt_prdata;
        pslverr_ff <= nxt_err;
        sel_ff     <= nxt_sel;
      end
      else if (done)
      begin
        pslverr_ff <= 1'b0;
        sel_ff     <= SEL_NONE;
      end
      // Control write lands only at the completing edge
      if (done && pwrite && !pslverr_ff && hit(paddr, `ULMS_ADDR_U1_CTRL))
        ctrl_ff <= pwdata[7:0];
    end
  end

  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
  assign fifo_mode       = ctrl_ff[`ULMS_CTRL_FIFO];
  assign rx_trigger_code = ctrl_ff[`ULMS_CTRL_TRIG_HI:`ULMS_CTRL_TRIG_LO];
  assign rx_store_block  = store_block_ff;
endmodule // ulms_status

// ### bench/ulms_status_checker.sv
// Port-level assertions for the serial-port status block
`timescale 1ns/1ps
`include "ulms_defs.vh"
module ulms_status_checker
#(
  parameter RX_DEPTH = 16,
  parameter TX_DEPTH = 16,
  parameter TX_HALF  = 8,
  parameter CNT_W    = 5
)
(
  input wire             pclk,
  input wire             presetn,
  input wire             psel,
  input wire             penable,
  input wire             pwrite,
  input wire [31:0]      paddr,
  input wire [31:0]      prdata,
  input wire             pready,
  input wire [CNT_W-1:0] rx_fifo_count,
  input wire [CNT_W-1:0] tx_fifo_count,
  input wire             tx_holding_full,
  input wire             tx_shift_busy,
  input wire             u1_dcd,
  input wire             u1_ri,
  input wire             u1_dsr,
  input wire             u1_cts,
  input wire             fifo_mode,
  input wire [2:0]       rx_trigger_code,
  input wire             rx_store_block
);
  // ********
  // Read snapshots are taken at the setup edge
  // ********
  wire       rd_l = psel && !penable && !pwrite && paddr == `ULMS_ADDR_U1_LINE;
  wire       rd_m = psel && !penable && !pwrite && paddr == `ULMS_ADDR_U1_MODEM;
  wire [3:0] m1   = {u1_dcd, u1_ri, u1_dsr, u1_cts};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_answer; psel && !penable |=> pready ##1 !pready; endproperty
  a_answer: assert property (p_answer) else $error("ready not one cycle");
  property p_err; rd_l |=> prdata[11] == |prdata[4:2]; endproperty
  a_err: assert property (p_err) else $error("error summary wrong");
  property p_off; rd_l && !fifo_mode |=> prdata[10:8] == 3'h0; endproperty
  a_off: assert property (p_off) else $error("queue flag outside queue mode");
  property p_full; rd_l && fifo_mode |=> prdata[8] == ($past(tx_fifo_count) == TX_DEPTH); endproperty
  a_full: assert property (p_full) else $error("tx full wrong");
  property p_half; rd_l |=> prdata[7] == ($past(tx_fifo_count) <= TX_HALF); endproperty
  a_half: assert property (p_half) else $error("tx half wrong");
  property p_trig;
    rd_l && fifo_mode |=> prdata[9] == ($past(rx_fifo_count) > 2 * $past(rx_trigger_code));
  endproperty
  a_trig: assert property (p_trig) else $error("trigger wrong");
  property p_holding_stage_empty;
    rd_l |=> prdata[5] == $past(fifo_mode ? tx_fifo_count == 0 : !tx_holding_full);
  endproperty
  a_holding_stage_empty: assert property (p_holding_stage_empty) else $error("holding empty wrong");
  property p_transmitter_idle;
    rd_l |=> prdata[6] == $past(!tx_shift_busy && (fifo_mode ? tx_fifo_count == 0 : !tx_holding_full));
  endproperty
  a_transmitter_idle: assert property (p_transmitter_idle) else $error("idle wrong");
  property p_dr; rd_l && fifo_mode |=> prdata[0] == ($past(rx_fifo_count) != 0); endproperty
  a_dr: assert property (p_dr) else $error("data ready wrong");
  property p_lvl; rd_m && $stable(m1) && $past(presetn) |=> prdata[7:4] == $past(m1); endproperty
  a_lvl: assert property (p_lvl) else $error("modem levels wrong");
  property p_blk; 1 |=> rx_store_block == $past(fifo_mode && rx_fifo_count == RX_DEPTH); endproperty
  a_blk: assert property (p_blk) else $error("store block wrong");
endmodule // ulms_status_checker
bind ulms_status ulms_status_checker #(.RX_DEPTH(RX_DEPTH), .TX_DEPTH(TX_DEPTH),
  .TX_HALF(TX_HALF), .CNT_W(CNT_W)) u_chk (.*);

// ### bench/ulms_partner.sv
// Remote serial device and modem on the receive side
`timescale 1ns/1ps
module ulms_partner
(
  input  logic       pclk,
  output logic       serial_receive_input,
  output logic       bit_tick,
  output logic       rx_char_done,
  output logic       rx_parity_bad,
  output logic       rx_stop_bad,
  output logic [3:0] lines
);
  int n;
  initial
  begin
    {serial_receive_input, rx_char_done, rx_parity_bad, rx_stop_bad} = 4'h8;
    lines = 4'h0;
  end
  // One bit time is four clocks to keep runs short
  always @(posedge pclk)
  begin
    n <= (n == 3) ? 0 : n + 1;
    bit_tick <= (n == 3);
  end
  task ticks(input int k);
    repeat (k) do @(posedge pclk); while (bit_tick !== 1'b1);
  endtask
  // Error qualifiers carry noise outside the completion pulse
  task send_char(input logic p, s);
    serial_receive_input <= 1'b0;
    ticks(1);
    repeat (8)
    begin
      serial_receive_input <= $urandom;
      ticks(1);
    end
    serial_receive_input <= !s;
    ticks(1);
    rx_char_done <= 1'b1;
    rx_parity_bad <= p;
    rx_stop_bad <= s;
    @(posedge pclk);
    rx_char_done <= 1'b0;
    rx_parity_bad <= $urandom;
    rx_stop_bad <= $urandom;
    serial_receive_input <= 1'b1;
  endtask
  task send_break;
    serial_receive_input <= 1'b0;
    ticks(14);
    serial_receive_input <= 1'b1;
    ticks(1);
  endtask
  task modem(input logic [3:0] v);
    @(posedge pclk);
    lines <= v;
  endtask
endmodule // ulms_partner

// ### bench/ulms_status_tb_top.sv
// Self-checking bench for the serial-port status block
`timescale 1ns/1ps
`include "ulms_defs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module ulms_status_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, f;
  logic [31:0] paddr, pwdata, prdata, rd, ex;
  logic        serial_receive_input, bit_tick, rx_char_done, rx_parity_bad, rx_stop_bad;
  logic        receive_buffer_read, rx_fifo_access, tx_holding_full, tx_shift_busy;
  logic        fifo_mode, rx_store_block;
  logic [4:0]  rx_fifo_count, tx_fifo_count;
  logic [2:0]  rx_trigger_code, code;
  logic [3:0]  m0, m1, v, pv;
  logic [4:0]  ctab [4] = '{5'h10, 5'h08, 5'h09, 5'h00};
  wire         u0_dcd, u0_ri, u0_dsr, u0_cts, u1_dcd, u1_ri, u1_dsr, u1_cts;
  int          mismatches, n_compared, cyc, i;
  assign {u0_dcd, u0_ri, u0_dsr, u0_cts} = m0;
  assign {u1_dcd, u1_ri, u1_dsr, u1_cts} = m1;
  ulms_status uut (.*);
  ulms_partner partner (.pclk(pclk), .serial_receive_input(serial_receive_input),
    .bit_tick(bit_tick), .rx_char_done(rx_char_done), .rx_parity_bad(rx_parity_bad),
    .rx_stop_bad(rx_stop_bad), .lines(m1));
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      give_verdict;
    end
  end
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ********
  // Bus cycles and expectations
  // ********
  task apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task rchk(input logic [31:0] a, m, e);
    apb(1'b0, a, 32'h0);
    `CHK(rd & m, e & m)
  endtask
  function logic [31:0] exp_line(input logic f, input logic [4:0] r, t,
                                 input logic [2:0] c, input logic h, b);
    logic e;
    e = f ? t == 0 : !h;
    exp_line = {22'h0, f && r > 2 * c, f && t == 5'h10, t <= 5'h08, e && !b, e, 4'h0,
                f && r != 0};
  endfunction
  initial
  begin
    {presetn, psel, penable, pwrite, receive_buffer_read, rx_fifo_access} = 6'h00;
    {tx_holding_full, tx_shift_busy, paddr, pwdata} = 66'h0;
    {rx_fifo_count, tx_fifo_count, m0, pv} = 18'h0;
    void'($urandom(44367));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`ULMS_ADDR_U1_LINE, 32'hFFFFFFFF, 32'hE0);
    rchk(`ULMS_ADDR_U1_MODEM, 32'hFFFFFFFF, 32'h0);
    rchk(`ULMS_ADDR_U0_MODEM, 32'hFFFFFFFF, 32'h0);
    apb(1'b1, `ULMS_ADDR_U1_LINE, 32'hFFF);
    `CHK(er, 1'b1)
    apb(1'b0, 32'hFFFF0760, 32'h0);
    `CHK(rd, 32'h0)
    $display("reset test done");
    partner.send_char(1'b0, 1'b0);
    rchk(`ULMS_ADDR_U1_LINE, 32'h3, 32'h1);
    partner.send_char(1'b0, 1'b0);
    rchk(`ULMS_ADDR_U1_LINE, 32'h3, 32'h3);
    rchk(`ULMS_ADDR_U1_LINE, 32'h3, 32'h1);
    @(posedge pclk);
    receive_buffer_read <= 1'b1;
    @(posedge pclk);
    receive_buffer_read <= 1'b0;
    rchk(`ULMS_ADDR_U1_LINE, 32'h1, 32'h0);
    for (i = 0; i < 3; i++)
    begin
      if (i == 2)
        partner.send_break;
      else
        partner.send_char(i == 0, i == 1);
      rchk(`ULMS_ADDR_U1_LINE, 32'h81C, 32'h800 | (32'h4 << i));
      rchk(`ULMS_ADDR_U1_LINE, 32'h81C, 32'h0);
    end
    $display("receive test done");
    for (i = 0; i < 24; i++)
    begin
      f = i[0];
      code = $urandom;
      @(posedge pclk);
      rx_fifo_count <= (i < 8) ? {1'b0, code, 1'b0} + i[1] : $urandom_range(16);
      tx_fifo_count <= (i < 8) ? ctab[i[2:1]] : $urandom_range(16);
      tx_holding_full <= $urandom;
      tx_shift_busy <= $urandom;
      rx_fifo_access <= $urandom;
      apb(1'b1, `ULMS_ADDR_U1_CTRL, {24'h0, code, 4'h0, f});
      @(negedge pclk);
      `CHK({fifo_mode, rx_trigger_code}, {f, code})
      ex = exp_line(f, rx_fifo_count, tx_fifo_count, code, tx_holding_full, tx_shift_busy);
      rchk(`ULMS_ADDR_U1_LINE, f ? 32'h3E1 : 32'h7E0, ex);
    end
    $display("flag test done");
    @(posedge pclk);
    {rx_fifo_count, rx_fifo_access} <= {5'h01, 1'b1};
    @(posedge pclk);
    rx_fifo_access <= 1'b0;
    partner.ticks(30);
    rchk(`ULMS_ADDR_U1_LINE, 32'h400, 32'h0);
    partner.ticks(15);
    rchk(`ULMS_ADDR_U1_LINE, 32'h400, 32'h400);
    @(posedge pclk);
    {rx_fifo_count, rx_fifo_access} <= {5'h10, 1'b1};
    @(posedge pclk);
    rx_fifo_access <= 1'b0;
    rchk(`ULMS_ADDR_U1_LINE, 32'h400, 32'h0);
    partner.send_char(1'b0, 1'b0);
    rchk(`ULMS_ADDR_U1_LINE, 32'h2, 32'h2);
    `CHK(rx_store_block, 1'b1)
    $display("queue test done");
    for (i = 0; i < 12; i++)
    begin
      v = (i < 4) ? 4'h1 << i : $urandom;
      partner.modem(v);
      repeat (3) @(posedge pclk);
      rchk(`ULMS_ADDR_U1_MODEM, 32'hFF, {24'h0, v, ((v ^ pv) & 4'hB) | (v & ~pv & 4'h4)});
      pv = v;
    end
    rchk(`ULMS_ADDR_U1_MODEM, 32'hF, 32'h0);
    @(posedge pclk);
    m0 <= 4'hF;
    repeat (3) @(posedge pclk);
    rchk(`ULMS_ADDR_U0_MODEM, 32'hFF, 32'hFF);
    rchk(`ULMS_ADDR_U0_MODEM, 32'hFF, 32'hF0);
    $display("modem test done");
    give_verdict;
  end
endmodule // ulms_status_tb_top
